// ---- verilog/itd_top.sv ----
// APB register hub for eight isochronous transmit contexts
`timescale 1ns/10ps
`include "itd_defines.svh"
module itd_top import itd_pkg::*; #(
   parameter int CTX_N = `ITD_CTX_N
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic swReset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Descriptor engine events, one bit per context; fetch address and event code are shared
   input wire logic [CTX_N-1:0] descFetch,
   input wire logic [31:0] fetchAddr,
   input wire logic [CTX_N-1:0] pauseIdle,
   input wire logic [CTX_N-1:0] lastDone,
   input wire logic [4:0] lastEvt,
   input wire logic [CTX_N-1:0] fatalErr,
   input wire logic [CTX_N-1:0] cycleSkip,
   input wire logic [CTX_N-1:0] cycleHit,
   // Context status toward the engine
   output logic [CTX_N-1:0] ctxRun,
   output logic [CTX_N-1:0] ctxActive,
   output logic [CTX_N-1:0] ctxWake,
   output logic [CTX_N-1:0] ctxStart,
   output logic [31:0] startAddr,
   // Toward the interrupt event register
   output logic fatalErrorEvent
);
   typedef struct packed {
      logic [31:0] rdata;
      logic [31:0] addr;
      logic [CTX_N-1:0] start;
      logic fatal;
   } itd_top_s_t;

   itd_top_s_t s;
   itd_top_s_t n;

   logic inWin;
   logic [2:0] idx;
   logic [1:0] sub;
   logic hit;
   logic access;
   logic setup;
   logic wrOk;
   logic [31:0] rdv;
   logic [CTX_N-1:0] reqVec;
   logic [CTX_N-1:0] gnt;
   logic [CTX_N-1:0] ovfVec;
   logic [CTX_N-1:0] actVec;
   logic [CTX_N-1:0] runVec;
   logic [CTX_N-1:0] wakeVec;
   logic [31:0] ctlRd [CTX_N];
   logic [31:0] ptrRd [CTX_N];

   itd_ctx_if cif [CTX_N] ();

   // Address decode: one 16-byte slot per context
   always_comb begin
      inWin = (paddr[11:7] == `ITD_BASE_HI);
      idx = paddr[6:4];
      sub = paddr[3:2];
      // R15 contexts 0 to CTX_N-1 only
      hit = inWin && ({29'h0, idx} < 32'(CTX_N));
      setup = psel && !penable;
      access = psel && penable;
      wrOk = access && pwrite && hit && (sub != `ITD_SUB_PTR);
   end

   // Zero wait states; the error answer covers holes and pointer writes
   assign pready = 1'b1;
   // R14 pointer is read-only at its own slot
   assign pslverr = access && (!hit || (pwrite && sub == `ITD_SUB_PTR));

   // Per-context wiring through the carrier
   for (genvar i = 0; i < CTX_N; i++) begin : g_ctx
      logic sel;
      assign sel = wrOk && (idx == 3'(i));
      // R1 set and clear slots steer run, wake and the rest
      assign cif[i].setStb = sel && (sub == `ITD_SUB_SET);
      assign cif[i].clrStb = sel && (sub == `ITD_SUB_CLR);
      assign cif[i].loadStb = sel && (sub == `ITD_SUB_LOAD);
      assign cif[i].wdata = pwdata;
      assign cif[i].swRst = swReset;
      assign cif[i].descFetch = descFetch[i];
      assign cif[i].fetchAddr = fetchAddr;
      assign cif[i].pauseIdle = pauseIdle[i];
      assign cif[i].lastDone = lastDone[i];
      assign cif[i].lastEvt = lastEvt;
      assign cif[i].fatalErr = fatalErr[i];
      assign cif[i].cycleSkip = cycleSkip[i];
      assign cif[i].cycleHit = cycleHit[i];
      assign cif[i].grant = gnt[i];
      assign reqVec[i] = cif[i].startReq;
      assign ovfVec[i] = cif[i].ovfFatal;
      assign actVec[i] = cif[i].active;
      assign runVec[i] = cif[i].run;
      assign wakeVec[i] = cif[i].wake;
      assign ctlRd[i] = cif[i].ctl;
      assign ptrRd[i] = cif[i].ptr;

      itd_ctx u_ctx (
         .clk_sys(clk_sys),
         .arst_n(arst_n),
         .bus(cif[i])
      );
   end

   // One start per cycle; the lowest context wins, the rest wait
   assign gnt = reqVec & (~reqVec + {{(CTX_N-1){1'b0}}, 1'b1});

   // Read mux for the addressed slot
   always_comb begin
      rdv = 32'h0000_0000;
      if (hit) begin
         if (sub == `ITD_SUB_PTR || sub == `ITD_SUB_LOAD) begin
            rdv = ptrRd[idx];
         end else begin
            rdv = ctlRd[idx];
         end
      end
   end

   // Next state of the hub
   always_comb begin
      n = s;
      // Read data is caught in the setup cycle, stable for the access
      if (setup && !pwrite) begin
         n.rdata = rdv;
      end
      // R13 first descriptor block address goes out with the start
      n.start = gnt;
      for (int i = 0; i < CTX_N; i++) begin
         if (gnt[i]) begin
            n.addr = ptrRd[i];
         end
      end
      // R12 skip overflow raises the fatal event toward interrupts
      n.fatal = |ovfVec;
   end

   // Hub register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs
   assign prdata = s.rdata;
   assign startAddr = s.addr;
   assign ctxStart = s.start;
   assign fatalErrorEvent = s.fatal;
   assign ctxRun = runVec;
   assign ctxActive = actVec;
   assign ctxWake = wakeVec;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   for (genvar i = 0; i < CTX_N; i++) begin : g_chk
      localparam logic [11:0] PtrAdr =
         12'(`ITD_CMDPTR_BASE + `ITD_CTX_STRIDE * i);
      a_reserved_zero: assert property ( // R3
         ctlRd[i][14:13] == 2'b00 && ctlRd[i][9:8] == 2'b00)
         else $error("reserved control bits not zero");
      a_speed_zero: assert property (ctlRd[i][7:5] == 3'h0) // R9
         else $error("speed field not zero");
      a_ptr_read: assert property (setup && !pwrite && // R14
         paddr == PtrAdr |=> prdata == $past(ptrRd[i]))
         else $error("command pointer read wrong");
      a_start_ptr: assert property (gnt[i] |=> ctxStart[i] && // R13
         ctxActive[i] && startAddr == $past(ptrRd[i]) ##1 !ctxStart[i])
         else $error("start pulse or address wrong");
      a_run_start: assert property ($rose(ctxRun[i]) && // R1
         !ctlRd[i][`ITD_B_SOC] && !swReset
         |-> ##[1:20] ctxStart[i] || !ctxRun[i])
         else $error("run did not start context");
   end

   a_ovf_event: assert property (|ovfVec |=> fatalErrorEvent) // R12
      else $error("fatal event not raised");
   a_unmapped_err: assert property (access && !inWin |-> pslverr) // R15
      else $error("unmapped access not refused");
   c_start: cover property (|ctxStart);
   c_ptr_read: cover property (setup && !pwrite &&
      sub == `ITD_SUB_PTR && hit && |actVec);
   c_fatal: cover property (fatalErrorEvent);
endmodule: itd_top

// ---- pkg/itd_defines.svh ----
// Constants of the isochronous transmit context status block
// Functional notes
// R1: Software sets run to start, clears to stop
// R2: Run changes only by software or reset
// R3: Control bits 14-13 and 9-8 read zero
// R4: Software sets wake to resume paused context
// R5: Every descriptor fetch clears wake (a software set of wake in the same cycle wins instead)
// R6: Fatal error sets dead (the code sets it only while the context is active or paused)
// R7: Clearing run clears dead
// R8: Active high while processing descriptors
// R9: Speed field carries nothing, reads zero
// R10: Last descriptor outcome lands in event code
// R11: Up to seven skipped cycles tolerated
// R12: Skip overflow: dead, timeout code, fatal event
// R13: Command pointer gives first block at start
// R14: Command pointer readable while active
// R15: Eight contexts, pointer at 20Ch plus 16n
// R16: Start-on-cycle enable cleared once active
// R17: Event codes use standard five-bit encodings
`ifndef ITD_DEFINES_SVH
`define ITD_DEFINES_SVH
`define ITD_CTX_N 8
`define ITD_BASE_HI 5'h04
`define ITD_CMDPTR_BASE 12'h20C
`define ITD_CTX_STRIDE 12'h010
`define ITD_SUB_SET 2'h0
`define ITD_SUB_CLR 2'h1
`define ITD_SUB_LOAD 2'h2
`define ITD_SUB_PTR 2'h3
`define ITD_B_SOC 31
`define ITD_CM_HI 30
`define ITD_CM_LO 16
`define ITD_B_RUN 15
`define ITD_B_WAKE 12
`define ITD_B_DEAD 11
`define ITD_B_ACT 10
`define ITD_EVT_NONE 5'h00
`define ITD_EVT_DESC_READ 5'h05
`define ITD_EVT_DATA_READ 5'h07
`define ITD_EVT_TIMEOUT 5'h0A
`define ITD_EVT_UNKNOWN 5'h0E
`define ITD_ACK_COMPLETE 5'h11
`define ITD_MAX_SKIP 3'h7
`define ITD_PTR_RST 32'h0000_0000
`endif

// ---- pkg/itd_pkg.sv ----
// Types of the isochronous transmit context status block
package itd_pkg;
   typedef enum logic [5:0] {
      ST_STOP  = 6'h01,
      ST_WAIT  = 6'h02,
      ST_REQ   = 6'h04,
      ST_ACT   = 6'h08,
      ST_PAUSE = 6'h10,
      ST_DEAD  = 6'h20
   } itd_st_t;

   typedef struct packed {
      itd_st_t st;
      logic run;
      logic wake;
      logic soc;
      logic [14:0] cm;
      logic dead;
      logic [4:0] evt;
      logic [2:0] skip;
      logic ovf;
      logic [31:0] ptr;
   } itd_ctx_s_t;
endpackage: itd_pkg

// ---- pkg/itd_ctx_if.sv ----
// Carrier between the register hub and one transmit context
`timescale 1ns/10ps
interface itd_ctx_if;
   logic setStb;
   logic clrStb;
   logic loadStb;
   logic swRst;
   logic [31:0] wdata;
   logic descFetch;
   logic [31:0] fetchAddr;
   logic pauseIdle;
   logic lastDone;
   logic [4:0] lastEvt;
   logic fatalErr;
   logic cycleSkip;
   logic cycleHit;
   logic grant;
   logic startReq;
   logic run;
   logic active;
   logic wake;
   logic ovfFatal;
   logic [31:0] ctl;
   logic [31:0] ptr;
   modport hub(output setStb, clrStb, loadStb, swRst, wdata, descFetch,
      fetchAddr, pauseIdle, lastDone, lastEvt, fatalErr, cycleSkip,
      cycleHit, grant, input startReq, run, active, wake, ovfFatal, ctl, ptr);
   modport ctx(input setStb, clrStb, loadStb, swRst, wdata, descFetch,
      fetchAddr, pauseIdle, lastDone, lastEvt, fatalErr, cycleSkip,
      cycleHit, grant, output startReq, run, active, wake, ovfFatal, ctl, ptr);
endinterface: itd_ctx_if

// ---- verilog/itd_ctx.sv ----
// One isochronous transmit context: control bits, state, pointer
`timescale 1ns/10ps
`include "itd_defines.svh"
module itd_ctx import itd_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Hub side
   itd_ctx_if.ctx bus
);
   itd_ctx_s_t s;
   itd_ctx_s_t n;
   logic runSet;
   logic runClr;
   logic live;
   logic overflow;
   logic fatalNow;

   // Next state of the context
   always_comb begin
      n = s;
      n.ovf = 1'b0;
      runSet = bus.setStb & bus.wdata[`ITD_B_RUN];
      runClr = bus.clrStb & bus.wdata[`ITD_B_RUN];
      live = (s.st == ST_ACT) | (s.st == ST_PAUSE);
      // R11 seven skips pass, the eighth is fatal
      overflow = bus.cycleSkip & (s.st == ST_ACT) & (s.skip == `ITD_MAX_SKIP);
      // R6 fatal error or skip overflow
      fatalNow = (bus.fatalErr & live) | overflow;
      // R2 run moves only by software or reset
      if (bus.swRst) begin
         n.run = 1'b0;
      end else if (runSet) begin
         n.run = 1'b1;
      end else if (runClr) begin
         n.run = 1'b0;
      end
      // R16 hardware clear on activation, software set wins
      if (bus.setStb & bus.wdata[`ITD_B_SOC]) begin
         n.soc = 1'b1;
      end else if ((bus.clrStb & bus.wdata[`ITD_B_SOC]) | bus.grant) begin
         n.soc = 1'b0;
      end
      if (bus.setStb) begin
         n.cm = s.cm | bus.wdata[`ITD_CM_HI:`ITD_CM_LO];
      end
      if (bus.clrStb) begin
         n.cm = n.cm & ~bus.wdata[`ITD_CM_HI:`ITD_CM_LO];
      end
      // R5 fetch clears wake, a same-cycle set wins
      if (bus.setStb & bus.wdata[`ITD_B_WAKE]) begin
         n.wake = 1'b1;
      end else if (bus.descFetch) begin
         n.wake = 1'b0;
      end
      // R13 pointer loads only while stopped, tracks fetches after
      if (bus.descFetch) begin
         n.ptr = bus.fetchAddr;
      end else if (bus.loadStb & (s.st == ST_STOP) & ~s.run) begin
         n.ptr = bus.wdata;
      end
      if (bus.lastDone) begin
         n.skip = 3'h0;
      end else if (bus.cycleSkip & (s.st == ST_ACT) & ~overflow) begin
         n.skip = s.skip + 3'h1;
      end
      // R10 outcome of the last descriptor
      if (bus.lastDone & (s.st == ST_ACT)) begin
         n.evt = bus.lastEvt;
      end
      // R12 overflow gives dead, timeout and the fatal event
      if (overflow) begin
         // R17 standard five-bit timeout code
         n.evt = `ITD_EVT_TIMEOUT;
         n.ovf = 1'b1;
      end
      // R7 dead drops once run is clear; a quick re-run must not keep it
      n.dead = fatalNow | (s.dead & s.run & n.run);
      unique case (s.st)
         ST_STOP: if (s.run) begin
            n.st = s.soc ? ST_WAIT : ST_REQ;
         end
         ST_WAIT: if (bus.cycleHit) begin
            n.st = ST_REQ;
         end
         ST_REQ: if (bus.grant) begin
            n.st = ST_ACT;
         end
         ST_ACT: if (fatalNow) begin
            n.st = ST_DEAD;
         end else if (bus.pauseIdle) begin
            n.st = ST_PAUSE;
         end
         // R4 wake resumes a paused context
         ST_PAUSE: if (fatalNow) begin
            n.st = ST_DEAD;
         end else if (s.wake) begin
            n.st = ST_ACT;
         end
         ST_DEAD: n.st = ST_DEAD;
         default: n.st = ST_STOP;
      endcase
      if (~n.run) begin
         n.st = ST_STOP;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s <= '{st: ST_STOP, ptr: `ITD_PTR_RST, default: '0};
      end else begin
         s <= n;
      end
   end

   // R3 R9 reserved and speed bits read zero
   assign bus.ctl = {s.soc, s.cm, s.run, 2'b00, s.wake, s.dead,
      s.st == ST_ACT, 5'h00, s.evt};
   // R8 active only in the processing state
   assign bus.active = (s.st == ST_ACT);
   assign bus.run = s.run;
   assign bus.wake = s.wake;
   assign bus.startReq = (s.st == ST_REQ);
   assign bus.ovfFatal = s.ovf;
   assign bus.ptr = s.ptr;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_wake_fetch: assert property (bus.descFetch && // R5
      !(bus.setStb && bus.wdata[`ITD_B_WAKE]) |=> !s.wake)
      else $error("wake not cleared by fetch");
   a_dead_fatal: assert property (bus.fatalErr && bus.active // R6
      |=> s.dead && !bus.active) else $error("fatal did not set dead");
   a_dead_clear: assert property ($past(!s.run) && !s.run // R7
      |-> !s.dead) else $error("dead stayed after run cleared");
   a_run_hold: assert property (!bus.swRst && // R2
      !((bus.setStb || bus.clrStb) && bus.wdata[`ITD_B_RUN])
      |=> s.run == $past(s.run)) else $error("run changed on its own");
   a_active_run: assert property (bus.active |-> s.run && !s.dead) // R8
      else $error("active without run");
   a_evt_last: assert property (bus.lastDone && bus.active && // R10
      !(bus.cycleSkip && s.skip == `ITD_MAX_SKIP)
      |=> s.evt == $past(bus.lastEvt)) else $error("event code lost");
   a_skip_ok: assert property (bus.active && bus.cycleSkip && // R11
      s.skip != `ITD_MAX_SKIP && !bus.fatalErr && !bus.pauseIdle &&
      s.run && !bus.swRst && !(bus.clrStb && bus.wdata[`ITD_B_RUN])
      |=> bus.active) else $error("skip under limit stopped context");
   a_skip_ovf: assert property (bus.active && bus.cycleSkip && // R12
      s.skip == `ITD_MAX_SKIP |=> s.dead && s.ovf &&
      s.evt == `ITD_EVT_TIMEOUT ##1 !s.ovf)
      else $error("skip overflow handling wrong");
   a_soc_clear: assert property (bus.grant && // R16
      !(bus.setStb && bus.wdata[`ITD_B_SOC]) |=> !s.soc)
      else $error("start-on-cycle not cleared");
   c_skip_ovf: cover property (bus.active && bus.cycleSkip &&
      s.skip == `ITD_MAX_SKIP);
   c_resume: cover property (s.st == ST_PAUSE ##1 s.st == ST_ACT);
endmodule: itd_ctx

// ---- testbench/itd_engine_model.sv ----
// Behavioural descriptor engine that fetches for started contexts
`timescale 1ns/10ps
module itd_engine_model import itd_pkg::*; #(
   parameter int CTX_N = 8,
   parameter int DLY = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Context status from the block
   input wire logic [CTX_N-1:0] ctxStart,
   input wire logic [31:0] startAddr,
   input wire logic [CTX_N-1:0] ctxActive,
   input wire logic [CTX_N-1:0] ctxWake,
   // Fetch reports to the block
   output logic [CTX_N-1:0] descFetch,
   output logic [31:0] fetchAddr
);
   int cnt [CTX_N];
   logic [31:0] nxt [CTX_N];

   // Shared address bus, so the lowest context wins a clash
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         descFetch <= '0;
         fetchAddr <= 32'h0;
         for (int n = 0; n < CTX_N; n++) begin
            cnt[n] <= 0;
            nxt[n] <= 32'h0;
         end
      end else begin
         descFetch <= '0;
         fetchAddr <= ~fetchAddr; // No stale address between fetches
         for (int n = CTX_N - 1; n >= 0; n--) begin
            if (ctxStart[n]) begin
               cnt[n] <= DLY;
               nxt[n] <= startAddr + 32'h10;
            end else if (cnt[n] > 0) begin
               cnt[n] <= cnt[n] - 1;
            end
            if (cnt[n] == 1 ||
               (ctxActive[n] && ctxWake[n] && !descFetch[n])) begin
               descFetch <= CTX_N'(1) << n;
               fetchAddr <= nxt[n];
               nxt[n] <= nxt[n] + 32'h10;
            end
         end
      end
   end
endmodule: itd_engine_model

// ---- testbench/tb.sv ----
// Self-checking bench for the transmit context status block
`timescale 1ns/10ps
`include "itd_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
   n_fail++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
   logic clk_sys, arst_n, swReset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, fetchAddr, startAddr, rd;
   logic [7:0] descFetch, pauseIdle, lastDone, fatalErr, cycleSkip, cycleHit;
   logic [7:0] ctxRun, ctxActive, ctxWake, ctxStart;
   logic [4:0] lastEvt;
   logic [4:0] codes [4];
   logic fatalErrorEvent, er;
   int n_fail, comparisons, k;

   itd_top #(.CTX_N(8)) DUT(.clk_sys(clk_sys), .arst_n(arst_n),
      .swReset(swReset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .descFetch(descFetch), .fetchAddr(fetchAddr),
      .pauseIdle(pauseIdle), .lastDone(lastDone), .lastEvt(lastEvt),
      .fatalErr(fatalErr), .cycleSkip(cycleSkip), .cycleHit(cycleHit),
      .ctxRun(ctxRun), .ctxActive(ctxActive), .ctxWake(ctxWake),
      .ctxStart(ctxStart), .startAddr(startAddr),
      .fatalErrorEvent(fatalErrorEvent));

   itd_engine_model #(.CTX_N(8), .DLY(2)) engine(.clk_sys(clk_sys),
      .arst_n(arst_n), .ctxStart(ctxStart), .startAddr(startAddr),
      .ctxActive(ctxActive), .ctxWake(ctxWake), .descFetch(descFetch),
      .fetchAddr(fetchAddr));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask: conclude

   function automatic logic [11:0] ad(input int n, input int s);
      return 12'h200 + 12'(16 * n + 4 * s);
   endfunction: ad

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int c;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      c = 0;
      do begin
         @(posedge clk_sys);
         c++;
      end while (pready !== 1'b1 && c < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         conclude();
      end
   endtask: apb

   task automatic chk(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd & m)
   endtask: chk

   // One-cycle event pulse toward the block
   task automatic pul(input int kd, input int n);
      @(posedge clk_sys);
      case (kd)
         0: pauseIdle[n] <= 1'b1;
         1: lastDone[n] <= 1'b1;
         2: fatalErr[n] <= 1'b1;
         3: cycleSkip[n] <= 1'b1;
         default: cycleHit[n] <= 1'b1;
      endcase
      @(posedge clk_sys);
      {pauseIdle, lastDone, fatalErr, cycleSkip, cycleHit} <= '0;
   endtask: pul

   // Bounded wait for a start (fetch 0) or fetch pulse, off the clock edge
   task automatic waitHi(input bit fetch, input int n);
      int c;
      logic b;
      b = fetch ? descFetch[n] : ctxStart[n];
      for (c = 0; c < 20 && b !== 1'b1; c++) begin
         @(negedge clk_sys);
         b = fetch ? descFetch[n] : ctxStart[n];
      end
      `CHK("wait", 1'b1, b)
      if (b !== 1'b1) begin
         conclude();
      end
   endtask: waitHi

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   initial begin
      {arst_n, swReset, psel, penable, pwrite, paddr, pwdata} = '0;
      {pauseIdle, lastDone, fatalErr, cycleSkip, cycleHit, lastEvt} = '0;
      codes = '{`ITD_ACK_COMPLETE, `ITD_EVT_DESC_READ, `ITD_EVT_DATA_READ,
         `ITD_EVT_UNKNOWN};
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Pointer load and the refused accesses
      apb(1'b1, ad(2, 2), 32'h0001_2340);
      chk(ad(2, 3), 32'hFFFF_FFFF, 32'h0001_2340, "pointer");
      apb(1'b1, ad(2, 3), 32'h0);
      `CHK("pointer write", 1'b1, er)
      apb(1'b0, 12'h300, 32'h0);
      `CHK("unmapped", 1'b1, er)
      // Run set with reserved and speed bits written as ones
      apb(1'b1, ad(2, 0), 32'h0000_E3E0);
      waitHi(1'b0, 2);
      `CHK("start address", 32'h0001_2340, startAddr)
      chk(ad(2, 0), 32'hFFFF_FFFF, 32'h0000_8400, "running");
      waitHi(1'b1, 2);
      chk(ad(2, 3), 32'hFFFF_FFFF, 32'h0001_2350, "pointer live");
      // Four outcome codes in turn land in the event field
      for (int i = 0; i < 4; i++) begin
         lastEvt <= codes[i];
         pul(1, 2);
         chk(ad(2, 0), 32'h1F, {27'h0, codes[i]}, "event");
      end
      pul(0, 2);
      chk(ad(2, 0), 32'h9400, 32'h8000, "paused");
      apb(1'b1, ad(2, 0), 32'h0000_1000);
      waitHi(1'b1, 2);
      chk(ad(2, 0), 32'h9400, 32'h8400, "wake cleared");
      `CHK("wake pin", 1'b0, ctxWake[2])
      // Seven skips are tolerated, the eighth kills the context
      for (int i = 0; i < 7; i++) pul(3, 2);
      chk(ad(2, 0), 32'h0C00, 32'h0400, "seven skips");
      pul(3, 2);
      for (k = 0; k < 8 && fatalErrorEvent !== 1'b1; k++) @(negedge clk_sys);
      `CHK("fatal event", 1'b1, fatalErrorEvent)
      if (fatalErrorEvent !== 1'b1) begin
         conclude();
      end
      chk(ad(2, 0), 32'h8C1F, 32'h880A, "overflow");
      apb(1'b1, ad(2, 1), 32'h0000_8000);
      repeat (2) @(posedge clk_sys);
      chk(ad(2, 0), 32'h8C00, 32'h0, "dead cleared");
      // Fatal error, then software reset stops the context
      apb(1'b1, ad(0, 0), 32'h0000_8000);
      waitHi(1'b0, 0);
      pul(2, 0);
      chk(ad(0, 0), 32'h8C00, 32'h8800, "fatal");
      swReset <= 1'b1;
      @(posedge clk_sys);
      swReset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(ad(0, 0), 32'h8C00, 32'h0, "software reset");
      `CHK("run pins", 8'h00, ctxRun)
      // Start held back until the cycle match arrives
      apb(1'b1, ad(1, 0), 32'h8005_8000);
      repeat (4) @(negedge clk_sys);
      `CHK("held", 1'b0, ctxActive[1])
      pul(4, 1);
      waitHi(1'b0, 1);
      chk(ad(1, 0), 32'hFFFF_FFFF, 32'h0005_8400, "match bit");
      // Clearing part of the match field leaves run alone
      apb(1'b1, ad(1, 1), 32'h0004_0000);
      chk(ad(1, 0), 32'hFFFF_FFFF, 32'h0001_8400, "match field");
      conclude();
   end
endmodule: tb
